// >>> design/sslf_divider.sv
/*
 * Programmable pulse divider: one output pulse for every ratio input ticks.
 * Assumes tick is a one-cycle pulse on clk; a ratio of zero acts as one.
 */
`timescale 1ns/100ps
`default_nettype none

module sslf_divider #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic [W-1:0] ratio,
    output logic pulse_ff
);
    logic [W-1:0] cnt_ff;
    wire logic [W-1:0] last_count = (ratio == '0) ? '0 : ratio - W'(1);
    wire logic wrap = tick && (cnt_ff >= last_count);
    wire logic [W-1:0] nxt_cnt = wrap ? '0 : (tick ? cnt_ff + W'(1) : cnt_ff);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pulse_ff <= wrap;
        end
    end

endmodule : sslf_divider

`default_nettype wire

// >>> design/sslf_pkg.sv
/*
 * Shared constants and types of the synthesizer serial load and lock flag block.
 * Assumes a single 100 MHz system clock; no other file defines these names.
 */
package sslf_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_W = 14;
    localparam int MAIN_W = 10;
    localparam int SWALLOW_W = 7;
    localparam int WORD_W = REF_W + MAIN_W + SWALLOW_W + 1;

    // Positions in the shift register once a whole word has arrived.
    localparam int REF_LSB = MAIN_W + SWALLOW_W + 1;
    localparam int MAIN_LSB = SWALLOW_W + 1;
    localparam int SWALLOW_LSB = 1;
    localparam int CTRL_POS = 0;

    localparam logic [2:0] UNIT_ADDRESS = 3'h2;

    localparam logic [REF_W-1:0] REF_RESET = 14'h0001;
    localparam logic [MAIN_W-1:0] MAIN_RESET = 10'h001;
    localparam logic [SWALLOW_W-1:0] SWALLOW_RESET = 7'h00;
    localparam logic [WORD_W-1:0] SHIFT_RESET = 32'h0000_0000;

    // In-phase window between the two divided edges.
    localparam int LOCK_WINDOW_NS = 200;
    localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AGE_W = 8;
    localparam logic [AGE_W-1:0] AGE_MAX = 8'hFF;
    localparam logic [AGE_W-1:0] LOCK_WINDOW = AGE_W'(LOCK_WINDOW_CYC);

    localparam int SYNC_N = 9;
    // The tune request idles high, so its synchroniser starts high as well,
    // which keeps the filter out of tuning mode right after reset.
    localparam logic [SYNC_N-1:0] SYNC_RESET = 9'h100;

    typedef struct packed {
        logic [REF_W-1:0] ref_ratio;
        logic [MAIN_W-1:0] main_ratio;
        logic [SWALLOW_W-1:0] swallow_ratio;
    } sslf_ratios_t;

    typedef enum logic [2:0] {
        SSLF_NARROW = 3'b001,
        SSLF_WIDE = 3'b010,
        SSLF_TUNE = 3'b100
    } sslf_mode_t;

endpackage : sslf_pkg

// >>> design/sslf_top.sv
/*
 * Digital control of a receiver frequency synthesizer: address-gated serial load
 * of reference, main and swallow dividers, dual-modulus feedback counting,
 * lock detection with lamp and flag, and loop-filter mode lines.
 * Assumes all controller lines and both divider inputs are asynchronous pins.
 */
//
// Contract
// [RULE1] Gates open only when the select lines read 010.
// [RULE2] While matched, latch, clock and data pass to the shift register.
// [RULE3] Data shifts in on each rising serial clock edge.
// [RULE4] A high latch enable copies the shift register into the divider latches.
// [RULE5] Reference, swallow and main dividers all load through the one serial path.
// [RULE6] Reference divider divides the reference input and feeds phase and lock logic.
// [RULE7] Swallow and main dividers count prescaler output; main output is the feedback.
// [RULE8] Lock indicator high while the divided edges are in phase, else low.
// [RULE9] When locked the lamp driver goes high, turning the lamp off.
// [RULE10] When locked the lock flag to the controller goes high.
// [RULE11] When unlocked the lamp lights and the lock flag goes low.
// [RULE12] Controller drives the reference select low for external, high for internal.
// [RULE13] Loop open, inverted filter gate and tune lines set the filter mode.
// [RULE14] Word is reference, main, swallow MSB first, then a control bit of one.
// [RULE15] Controller checks the lock flag after every new load.
// [RULE16] Without an address match the gated lines are held low.
`timescale 1ns/100ps
`default_nettype none

module sslf_top
    import sslf_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic unit_select_bit0,
    input wire logic unit_select_bit1,
    input wire logic unit_select_bit2,
    input wire logic latch_enable_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic internal_ref_select,
    input wire logic reference_clock_input,
    input wire logic prescaler_input,
    input wire logic tune_request_n,
    output logic gated_latch_ff,
    output logic gated_clock_ff,
    output logic gated_data_ff,
    output sslf_pkg::sslf_ratios_t ratios_ff,
    output logic internal_osc_enable_ff,
    output logic divided_reference_ff,
    output logic divided_feedback_ff,
    output logic modulus_control_ff,
    output logic phase_lock_indicator_ff,
    output logic lock_alarm_lamp_ff,
    output logic lock_flag_ff,
    output logic loop_open_ff,
    output logic filter_gate_n_ff,
    output logic tune_ctrl_ff
);
    import sslf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Every pin passes two flip-flops before any logic looks at it.
    wire logic [SYNC_N-1:0] pins = {tune_request_n, prescaler_input, reference_clock_input,
        internal_ref_select, serial_data_in, serial_clock_in, latch_enable_in,
        unit_select_bit2, unit_select_bit1};
    logic [SYNC_N-1:0] meta_ff;
    logic [SYNC_N-1:0] sync_ff;
    logic sel0_meta_ff;
    logic sel0_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= SYNC_RESET;
            sync_ff <= SYNC_RESET;
            sel0_meta_ff <= 1'b0;
            sel0_ff <= 1'b0;
        end else begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
            sel0_meta_ff <= unit_select_bit0;
            sel0_ff <= sel0_meta_ff;
        end
    end

    wire logic sel1 = sync_ff[0];
    wire logic sel2 = sync_ff[1];
    wire logic latch_s = sync_ff[2];
    wire logic sclk_s = sync_ff[3];
    wire logic sdata_s = sync_ff[4];
    wire logic int_ref_s = sync_ff[5];
    wire logic ref_s = sync_ff[6];
    wire logic presc_s = sync_ff[7];
    wire logic tune_req_n_s = sync_ff[8];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and input gates.
    wire logic addr_match = ({sel0_ff, sel1, sel2} == UNIT_ADDRESS); // [RULE1]
    wire logic nxt_gated_latch = addr_match & latch_s; // [RULE2] [RULE16]
    wire logic nxt_gated_clock = addr_match & sclk_s; // [RULE2] [RULE16]
    wire logic nxt_gated_data = addr_match & sdata_s; // [RULE2] [RULE16]

    ////////////////////////////////////////////////////////////////////////////
    // Serial shift register and divider latches.
    logic [WORD_W-1:0] shift_ff;
    wire logic shift_edge = nxt_gated_clock & ~gated_clock_ff; // [RULE3]
    wire logic latch_edge = nxt_gated_latch & ~gated_latch_ff;
    wire logic [WORD_W-1:0] nxt_shift = shift_edge ? {shift_ff[WORD_W-2:0], nxt_gated_data}
        : shift_ff; // [RULE3] [RULE14]
    // A word without its trailing control bit is ignored, which guards
    // against a load strobe after a short or aborted transfer.
    wire logic do_latch = latch_edge & shift_ff[CTRL_POS]; // [RULE4] [RULE14]
    wire sslf_ratios_t word_ratios = '{
        ref_ratio: shift_ff[REF_LSB +: REF_W],
        main_ratio: shift_ff[MAIN_LSB +: MAIN_W],
        swallow_ratio: shift_ff[SWALLOW_LSB +: SWALLOW_W]}; // [RULE5] [RULE14]
    wire sslf_ratios_t nxt_ratios = do_latch ? word_ratios : ratios_ff; // [RULE4]

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gated_latch_ff <= 1'b0;
            gated_clock_ff <= 1'b0;
            gated_data_ff <= 1'b0;
            shift_ff <= SHIFT_RESET;
            ratios_ff <= '{REF_RESET, MAIN_RESET, SWALLOW_RESET};
        end else begin
            gated_latch_ff <= nxt_gated_latch;
            gated_clock_ff <= nxt_gated_clock;
            gated_data_ff <= nxt_gated_data;
            shift_ff <= nxt_shift;
            ratios_ff <= nxt_ratios;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference and feedback dividers.
    logic ref_prev_ff;
    logic presc_prev_ff;
    logic [SWALLOW_W-1:0] swallow_cnt_ff;
    wire logic ref_tick = ref_s & ~ref_prev_ff;
    wire logic presc_tick = presc_s & ~presc_prev_ff;
    wire logic ref_pulse;
    wire logic fb_pulse;

    sslf_divider #(.W(REF_W)) u_ref_div (
        .clk(clk),
        .reset_n(reset_n),
        .tick(ref_tick),
        .ratio(ratios_ff.ref_ratio),
        .pulse_ff(ref_pulse)
    ); // [RULE6]

    sslf_divider #(.W(MAIN_W)) u_main_div (
        .clk(clk),
        .reset_n(reset_n),
        .tick(presc_tick),
        .ratio(ratios_ff.main_ratio),
        .pulse_ff(fb_pulse)
    ); // [RULE7]

    // The swallow count restarts with each feedback cycle and holds the
    // prescaler in its higher modulus until the programmed count is reached.
    wire logic swallow_run = swallow_cnt_ff < ratios_ff.swallow_ratio;
    wire logic [SWALLOW_W-1:0] nxt_swallow_cnt = fb_pulse ? '0
        : ((presc_tick && swallow_run) ? swallow_cnt_ff + SWALLOW_W'(1)
        : swallow_cnt_ff); // [RULE7]
    wire logic nxt_modulus = nxt_swallow_cnt < ratios_ff.swallow_ratio; // [RULE7]

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_prev_ff <= 1'b0;
            presc_prev_ff <= 1'b0;
            swallow_cnt_ff <= '0;
            modulus_control_ff <= 1'b0;
            divided_reference_ff <= 1'b0;
            divided_feedback_ff <= 1'b0;
            internal_osc_enable_ff <= 1'b0;
        end else begin
            ref_prev_ff <= ref_s;
            presc_prev_ff <= presc_s;
            swallow_cnt_ff <= nxt_swallow_cnt;
            modulus_control_ff <= nxt_modulus;
            divided_reference_ff <= ref_pulse; // [RULE6]
            divided_feedback_ff <= fb_pulse; // [RULE7]
            internal_osc_enable_ff <= int_ref_s; // [RULE12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock detector, fault outputs and loop-filter mode.
    logic [AGE_W-1:0] ref_age_ff;
    logic [AGE_W-1:0] fb_age_ff;
    wire logic [AGE_W-1:0] nxt_ref_age = ref_pulse ? '0
        : ((ref_age_ff == AGE_MAX) ? ref_age_ff : ref_age_ff + AGE_W'(1));
    wire logic [AGE_W-1:0] nxt_fb_age = fb_pulse ? '0
        : ((fb_age_ff == AGE_MAX) ? fb_age_ff : fb_age_ff + AGE_W'(1));
    // A missing feedback edge unlocks one window after the reference edge.
    wire logic ref_unpaired = (ref_age_ff == LOCK_WINDOW + AGE_W'(1)) && (fb_age_ff > ref_age_ff);
    // A reference edge with no feedback edge since the one before it is out
    // of phase, which catches a dead prescaler even at short reference periods.
    wire logic ref_lonely = ref_pulse && (fb_age_ff > ref_age_ff);
    wire logic nxt_lock = fb_pulse ? (ref_pulse || (ref_age_ff <= LOCK_WINDOW))
        : (ref_pulse && fb_age_ff <= LOCK_WINDOW) ? 1'b1
        : (ref_unpaired || ref_lonely) ? 1'b0 : phase_lock_indicator_ff; // [RULE8]
    wire sslf_mode_t mode = !tune_req_n_s ? SSLF_TUNE
        : (nxt_lock ? SSLF_NARROW : SSLF_WIDE); // [RULE13]

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_age_ff <= AGE_MAX;
            fb_age_ff <= AGE_MAX;
            phase_lock_indicator_ff <= 1'b0;
            lock_alarm_lamp_ff <= 1'b0;
            lock_flag_ff <= 1'b0;
            loop_open_ff <= 1'b0;
            filter_gate_n_ff <= 1'b0;
            tune_ctrl_ff <= 1'b0;
        end else begin
            ref_age_ff <= nxt_ref_age;
            fb_age_ff <= nxt_fb_age;
            phase_lock_indicator_ff <= nxt_lock; // [RULE8]
            lock_alarm_lamp_ff <= nxt_lock; // [RULE9] [RULE11]
            lock_flag_ff <= nxt_lock; // [RULE10] [RULE11] [RULE15]
            loop_open_ff <= (mode == SSLF_TUNE); // [RULE13]
            filter_gate_n_ff <= (mode == SSLF_NARROW); // [RULE13]
            tune_ctrl_ff <= (mode == SSLF_TUNE); // [RULE13]
        end
    end

endmodule : sslf_top

`default_nettype wire

// >>> sim/sslf_ctrl_model.sv
/* Station controller model driving address and serial programming lines.
   Assumes the block clock paces every change. */
`timescale 1ns/100ps
`default_nettype none
module sslf_ctrl_model (
    input wire logic clk,
    output var logic unit_select_bit0,
    output var logic unit_select_bit1,
    output var logic unit_select_bit2,
    output var logic latch_enable_in,
    output var logic serial_clock_in,
    output var logic serial_data_in,
    output var logic internal_ref_select
);
    initial begin
        {unit_select_bit0, unit_select_bit1, unit_select_bit2} = 3'h0;
        {latch_enable_in, serial_clock_in, serial_data_in, internal_ref_select} = 4'h1;
    end
    // Four clocks a level, so the two-flop sync never loses an edge.
    task automatic send(input logic [2:0] adr, input logic [31:0] word);
        @(posedge clk);
        {unit_select_bit0, unit_select_bit1, unit_select_bit2} <= adr;
        for (int i = 31; i >= 0; i--) begin
            repeat (4) @(posedge clk);
            {serial_clock_in, serial_data_in} <= {1'b0, word[i]};
            repeat (4) @(posedge clk);
            serial_clock_in <= 1'b1;
        end
        repeat (4) @(posedge clk);
        serial_clock_in <= 1'b0;
        serial_data_in <= ~serial_data_in;
        repeat (4) @(posedge clk);
        latch_enable_in <= 1'b1;
        repeat (4) @(posedge clk);
        latch_enable_in <= 1'b0;
        {unit_select_bit0, unit_select_bit1, unit_select_bit2} <= 3'h0;
    endtask : send
    task automatic set_ref(input logic internal);
        @(posedge clk);
        internal_ref_select <= internal;
    endtask : set_ref
endmodule : sslf_ctrl_model
`default_nettype wire

// >>> sim/sslf_top_assertions.sv
/* Port checker for sslf_top, bound below.
   Assumes pins hold each level four clocks or more. */
`timescale 1ns/100ps
`default_nettype none
module sslf_top_assertions
    import sslf_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic unit_select_bit0,
    input wire logic unit_select_bit1,
    input wire logic unit_select_bit2,
    input wire logic serial_clock_in,
    input wire logic latch_enable_in,
    input wire logic serial_data_in,
    input wire logic tune_request_n,
    input wire logic gated_latch_ff,
    input wire logic gated_clock_ff,
    input wire logic gated_data_ff,
    input wire sslf_pkg::sslf_ratios_t ratios_ff,
    input wire logic divided_reference_ff,
    input wire logic divided_feedback_ff,
    input wire logic phase_lock_indicator_ff,
    input wire logic lock_alarm_lamp_ff,
    input wire logic lock_flag_ff,
    input wire logic loop_open_ff,
    input wire logic filter_gate_n_ff,
    input wire logic tune_ctrl_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic hit = !unit_select_bit0 && unit_select_bit1 && !unit_select_bit2;
    wire logic lk = phase_lock_indicator_ff;
    a_gate_closed: assert property (
        (!hit) [*4] |=> !gated_clock_ff && !gated_latch_ff && !gated_data_ff)
        else $error("gated line active while unmatched");
    a_gate_open: assert property ((hit && serial_clock_in) [*4] |=> gated_clock_ff)
        else $error("serial clock not passed");
    a_data_pass: assert property ((hit && serial_data_in) [*4] |=> gated_data_ff)
        else $error("serial data not passed");
    a_latch_pass: assert property ((hit && latch_enable_in) [*4] |=> gated_latch_ff)
        else $error("latch enable not passed");
    a_ratio_latch: assert property ($changed(ratios_ff) |-> $rose(gated_latch_ff))
        else $error("ratios changed without latch");
    a_locked_lamp: assert property (lk |-> lock_alarm_lamp_ff && lock_flag_ff)
        else $error("lamp or flag low while locked");
    a_unlocked_lamp: assert property (!lk |-> !lock_alarm_lamp_ff && !lock_flag_ff)
        else $error("lamp or flag high while unlocked");
    a_lock_cause: assert property ($rose(lk) |-> $past(divided_feedback_ff) ||
        $past(divided_reference_ff) || divided_feedback_ff || divided_reference_ff)
        else $error("lock without a divided edge");
    a_ref_pulse: assert property (divided_reference_ff |=> !divided_reference_ff)
        else $error("reference pulse too long");
    a_tune_mode: assert property ((!tune_request_n) [*4] |=>
        loop_open_ff && tune_ctrl_ff && !filter_gate_n_ff) else $error("tune mode lines wrong");
endmodule : sslf_top_assertions
bind sslf_top sslf_top_assertions u_sslf_top_assertions (
    .clk, .reset_n, .unit_select_bit0, .unit_select_bit1, .unit_select_bit2,
    .serial_clock_in, .latch_enable_in, .serial_data_in,
    .tune_request_n, .gated_latch_ff, .gated_clock_ff, .gated_data_ff,
    .ratios_ff, .divided_reference_ff, .divided_feedback_ff, .phase_lock_indicator_ff,
    .lock_alarm_lamp_ff, .lock_flag_ff, .loop_open_ff, .filter_gate_n_ff, .tune_ctrl_ff
);
`default_nettype wire

// >>> sim/sslf_top_test.sv
/* Self-checking bench of sslf_top with the controller model.
   Assumes only the package and the two sim modules. */
`timescale 1ns/100ps
`default_nettype none
module sslf_top_test;
    import sslf_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic pre_run = 1'b0;
    logic tune_request_n = 1'b1;
    logic [2:0] phase = 3'h0;
    wire logic unit_select_bit0, unit_select_bit1, unit_select_bit2, internal_ref_select;
    wire logic latch_enable_in, serial_clock_in, serial_data_in;
    sslf_ratios_t ratios_ff;
    logic gated_latch_ff, gated_clock_ff, gated_data_ff, internal_osc_enable_ff;
    logic divided_reference_ff, divided_feedback_ff, modulus_control_ff;
    logic phase_lock_indicator_ff, lock_alarm_lamp_ff, lock_flag_ff;
    logic loop_open_ff, filter_gate_n_ff, tune_ctrl_ff;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    always @(posedge clk) phase <= phase + 3'h1;
    sslf_ctrl_model u_sslf_ctrl_model (
        .clk, .unit_select_bit0, .unit_select_bit1, .unit_select_bit2,
        .latch_enable_in, .serial_clock_in, .serial_data_in, .internal_ref_select
    );
    sslf_top u_sslf_top (
        .clk, .reset_n, .unit_select_bit0, .unit_select_bit1, .unit_select_bit2,
        .latch_enable_in, .serial_clock_in, .serial_data_in, .internal_ref_select,
        .reference_clock_input(phase[2]), .prescaler_input(phase[2] & pre_run),
        .tune_request_n, .gated_latch_ff, .gated_clock_ff, .gated_data_ff, .ratios_ff,
        .internal_osc_enable_ff, .divided_reference_ff, .divided_feedback_ff,
        .modulus_control_ff, .phase_lock_indicator_ff, .lock_alarm_lamp_ff,
        .lock_flag_ff, .loop_open_ff, .filter_gate_n_ff, .tune_ctrl_ff
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic test_lock();
        @(posedge clk) pre_run <= 1'b1;
        settle(60);
        check({phase_lock_indicator_ff, lock_alarm_lamp_ff, lock_flag_ff}, 32'h7);
        check({loop_open_ff, filter_gate_n_ff, tune_ctrl_ff}, 32'h2);
        @(posedge clk) pre_run <= 1'b0;
        settle(60);
        check({phase_lock_indicator_ff, lock_alarm_lamp_ff, lock_flag_ff}, 32'h0);
        check({loop_open_ff, filter_gate_n_ff, tune_ctrl_ff}, 32'h0);
        $display("test lock finished");
    endtask : test_lock
    task automatic test_load();
        sslf_ratios_t want;
        int n_ref;
        int n_fb;
        int n_mod;
        want = '{ref_ratio: 14'h1234, main_ratio: 10'h2a5, swallow_ratio: 7'h5a};
        u_sslf_ctrl_model.send(3'h2, {want, 1'b1});
        settle(8);
        check(ratios_ff, want);
        for (int a = 0; a < 8; a++) begin
            if (a != 2) u_sslf_ctrl_model.send(a[2:0], 32'hffff_ffff);
        end
        u_sslf_ctrl_model.send(3'h2, 32'h0000_0006);
        settle(8);
        check(ratios_ff, want);
        // Equal small ratios keep both divided edges inside the lock window.
        want = '{ref_ratio: 14'h0002, main_ratio: 10'h002, swallow_ratio: 7'h01};
        u_sslf_ctrl_model.send(3'h2, {want, 1'b1});
        @(posedge clk) pre_run <= 1'b1;
        settle(80);
        check(ratios_ff, want);
        check(lock_flag_ff, 1'b1);
        // Ratio two on an eight-cycle input gives one pulse every sixteen cycles.
        n_ref = 0;
        n_fb = 0;
        n_mod = 0;
        repeat (160) begin
            settle(1);
            n_ref += divided_reference_ff;
            n_fb += divided_feedback_ff;
            n_mod += modulus_control_ff;
        end
        check(n_ref, 32'h0000_000a);
        check(n_fb, 32'h0000_000a);
        check((n_mod > 0) && (n_mod <= 80), 1'b1);
        @(posedge clk) pre_run <= 1'b0;
        $display("test load finished");
    endtask : test_load
    task automatic test_mode();
        @(posedge clk) tune_request_n <= 1'b0;
        settle(8);
        check({loop_open_ff, filter_gate_n_ff, tune_ctrl_ff}, 32'h5);
        @(posedge clk) tune_request_n <= 1'b1;
        u_sslf_ctrl_model.set_ref(1'b0);
        settle(8);
        check(internal_osc_enable_ff, 1'b0);
        u_sslf_ctrl_model.set_ref(1'b1);
        settle(8);
        check(internal_osc_enable_ff, 1'b1);
        $display("test mode finished");
    endtask : test_mode
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        test_lock();
        test_load();
        test_mode();
        stop_test();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            bad_count++;
            stop_test();
        end
    end
endmodule : sslf_top_test
`default_nettype wire
